/* logic/audio_dsp_core_datapath.sv */
// Fixed-point SIMD audio core: sequencer, multipliers, ALUs, address units, clipper
`timescale 1ns/1ps
`default_nettype none
module audio_dsp_core_datapath #(
   parameter int CYCLE_BUDGET = dsp_core_pkg::FULL_BUDGET
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Frame control
   input wire logic frame_start,
   input wire logic rate_lowered,
   input wire logic [dsp_core_pkg::CNT_W-1:0] block_len,
   // Program load port
   input wire logic prog_we,
   input wire logic [dsp_core_pkg::PC_W-1:0] prog_waddr,
   input wire logic [dsp_core_pkg::WORD_W-1:0] prog_wdata,
   // Data memory port
   output logic [dsp_core_pkg::MEM_AW-1:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [dsp_core_pkg::LINE_W-1:0] mem_wdata,
   input wire logic [dsp_core_pkg::LINE_W-1:0] mem_rdata,
   // Serial sample path
   input wire logic [dsp_core_pkg::SER_W-1:0] in_sample,
   output logic [dsp_core_pkg::SER_W-1:0] out_sample,
   output logic [3:0] out_chan,
   output logic out_valid,
   // Status
   output logic running,
   output logic sample_irq,
   output logic block_irq,
   output logic budget_err,
   output logic overrun
);
   import dsp_core_pkg::*;
   // ==========================================================
   // State
   typedef struct packed {
      state_t state;
      logic [PC_W-1:0] pc;
      logic [ACC_N-1:0][ACC_W-1:0] acc;
      logic [LINE_W-1:0] coef;
      logic [LINE_W-1:0] data;
      logic [AG_N-1:0][MEM_AW-1:0] ag_base;
      logic [AG_N-1:0][MEM_AW-1:0] ag_len;
      logic [AG_N-1:0][MEM_AW-1:0] ag_ptr;
      logic [WORD_W-1:0] lfsr;
      logic ld_wait;
      logic ld_coef;
      logic [CNT_W-1:0] cyc;
      logic [CNT_W-1:0] blk_cnt;
      logic blk_frame;
      logic [MEM_AW-1:0] mem_addr;
      logic mem_rd;
      logic mem_wr;
      logic mem_ld_coef;
      logic [LINE_W-1:0] mem_wdata;
      logic [SER_W-1:0] out_sample;
      logic [3:0] out_chan;
      logic out_valid;
      logic sample_irq;
      logic block_irq;
      logic budget_err;
      logic overrun;
   } core_state_t;
   core_state_t s_q, s_d;
   prog_if pif ();
   prog_mem u_prog_mem (
      .clk(clk),
      .rst(rst),
      .port(pif)
   );
   // Writes only land while stopped, so a running program never sees a torn word
   assign pif.we = prog_we && (s_q.state == ST_IDLE);
   assign pif.waddr = prog_waddr;
   assign pif.wdata = prog_wdata;
   assign pif.raddr = s_d.pc;
   // ==========================================================
   // Datapath temporaries
   instr_t ins;
   logic exec;
   logic [MUL_N-1:0][ACC_W-1:0] prod_acc;
   logic signed [PROD_W-1:0] prod;
   logic [ACC_W-1:0] a, b, c, mac_exp, alu_sum;
   logic signed [ACC_W-1:0] sa, sb, sdiff;
   logic [ACC_W-1:0] mag;
   logic [6:0] msb;
   logic [7:0] ex;
   logic [MEM_AW:0] ag_sum, ag_lim;
   logic [MEM_AW-1:0] ag_nxt;
   logic ag_in_range, clip_ok;
   logic [SER_W-1:0] clip_val;
   logic [WORD_W-1:0] in_word;
   logic [PC_W-1:0] pc_inc;
   logic [3:0] rd1;
   always_comb begin
      s_d = s_q;
      ins = instr_t'(pif.rdata);
      exec = (s_q.state == ST_RUN) && !frame_start;
      a = s_q.acc[ins.ra];
      b = s_q.acc[ins.rb];
      c = s_q.acc[ins.rd];
      rd1 = ins.rd ^ 4'h1;
      pc_inc = s_q.pc + 13'h1;
      sa = '0;
      sb = '0;
      sdiff = '0;
      prod = '0;
      // Four 8.56 x 8.24 products realigned to 24.56
      for (int i = 0; i < MUL_N; i++) begin
         prod = $signed(s_q.coef[COEF_W*i +: COEF_W]) *
                $signed(s_q.data[WORD_W*i +: WORD_W]);
         prod_acc[i] = {{HEAD_BITS{prod[PROD_W-1]}}, prod[PROD_W-1:FRAC_DATA]};
      end
      mac_exp = c + prod_acc[0] + prod_acc[1];
      alu_sum = a + b;
      // Circular post-step for the selected address generator
      ag_sum = {1'b0, s_q.ag_ptr[ins.ag]} + {6'h00, ins.imm};
      ag_lim = {1'b0, s_q.ag_base[ins.ag]} + {1'b0, s_q.ag_len[ins.ag]};
      if (s_q.ag_len[ins.ag] != '0 && ag_sum >= ag_lim) begin
         ag_sum = ag_sum - {1'b0, s_q.ag_len[ins.ag]};
      end
      ag_nxt = ag_sum[MEM_AW-1:0];
      ag_in_range = (s_q.ag_ptr[ins.ag] - s_q.ag_base[ins.ag]) < s_q.ag_len[ins.ag];
      // Clip 24.56 to 1.23: in range only if bits 79..56 agree
      clip_ok = (a[ACC_W-1:FRAC_ACC] == {(ACC_W-FRAC_ACC){a[FRAC_ACC]}});
      clip_val = clip_ok ? a[FRAC_ACC:FRAC_ACC-SER_W+1] :
                 (a[ACC_W-1] ? CLIP_MIN : CLIP_MAX);
      // 1.23 serial word into 8.24 with seven sign copies of headroom
      in_word = {{(HEAD_BITS-1){in_sample[SER_W-1]}}, in_sample, 1'b0};
      mag = a[ACC_W-1] ? (80'h0 - a) : a;
      msb = '0;
      for (int i = 0; i < ACC_W; i++) begin
         if (mag[i]) begin
            msb = 7'(i);
         end
      end
      ex = a[63:56];
      // ==========================================================
      // Defaults for pulses and memory handshake
      s_d.out_valid = 1'b0;
      s_d.sample_irq = 1'b0;
      s_d.block_irq = 1'b0;
      s_d.mem_rd = 1'b0;
      s_d.mem_wr = 1'b0;
      s_d.ld_wait = s_q.mem_rd;
      s_d.ld_coef = s_q.mem_ld_coef;
      s_d.cyc = (s_q.cyc == 16'hffff) ? s_q.cyc : s_q.cyc + 16'h0001;
      // ==========================================================
      // Instruction execute
      if (exec) begin
         s_d.pc = pc_inc;
         if (s_q.pc == PC_LAST) begin
            s_d.state = ST_IDLE;
         end
         case (ins.op)
            OP_HALT: begin
               s_d.state = ST_IDLE;
            end
            OP_LDC, OP_LDD: begin
               s_d.mem_rd = 1'b1;
               s_d.mem_addr = s_q.ag_ptr[ins.ag];
               s_d.mem_ld_coef = (ins.op == OP_LDC);
               s_d.ag_ptr[ins.ag] = ag_nxt;
            end
            OP_ST: begin
               s_d.mem_wr = 1'b1;
               s_d.mem_addr = s_q.ag_ptr[ins.ag];
               s_d.mem_wdata = s_q.data;
               s_d.ag_ptr[ins.ag] = ag_nxt;
            end
            OP_MAC: begin
               s_d.acc[ins.rd] = mac_exp;
               s_d.acc[rd1] = s_q.acc[rd1] + prod_acc[2] + prod_acc[3];
            end
            OP_CLR: begin
               s_d.acc[ins.rd] = '0;
               s_d.acc[rd1] = '0;
            end
            OP_ADD: begin
               s_d.acc[ins.rd] = alu_sum;
               s_d.acc[rd1] = s_q.acc[ins.ra ^ 4'h1] + s_q.acc[ins.rb ^ 4'h1];
            end
            OP_SUB: begin
               s_d.acc[ins.rd] = a - b;
               s_d.acc[rd1] = s_q.acc[ins.ra ^ 4'h1] - s_q.acc[ins.rb ^ 4'h1];
            end
            OP_IADD: begin
               s_d.data[WORD_W*ins.rd[2:0] +: WORD_W] =
                  s_q.data[WORD_W*ins.ra[2:0] +: WORD_W] +
                  s_q.data[WORD_W*ins.rb[2:0] +: WORD_W];
            end
            OP_IN: begin
               s_d.data[WORD_W*ins.imm[2:0] +: WORD_W] = in_word;
            end
            OP_OUT: begin
               s_d.out_sample = clip_val;
               s_d.out_chan = ins.imm[3:0];
               s_d.out_valid = 1'b1;
            end
            OP_AGB: begin
               s_d.ag_base[ins.ag] = 16'(ins.imm);
               s_d.ag_ptr[ins.ag] = 16'(ins.imm);
            end
            OP_AGL: begin
               s_d.ag_len[ins.ag] = 16'(ins.imm);
            end
            OP_JMP: begin
               s_d.pc = {ins.rd[1:0], ins.imm};
               s_d.state = ST_RUN;
            end
            OP_JBLK: begin
               if (s_q.blk_frame) begin
                  s_d.pc = {ins.rd[1:0], ins.imm};
                  s_d.state = ST_RUN;
               end
            end
            OP_SHF: begin
               sa = $signed(a) >>> ins.imm[6:0];
               s_d.acc[ins.rd] = ins.imm[10] ? sa : (a << ins.imm[6:0]);
            end
            OP_LOG2: begin
               ex = {1'b0, msb} - 8'd56;
               s_d.acc[ins.rd] = {{16{ex[7]}}, ex, 56'h0};
            end
            OP_EXP2: begin
               s_d.acc[ins.rd] = ex[7] ? (ACC_ONE >> (8'h00 - ex)) : (ACC_ONE << ex);
            end
            OP_DIVS: begin
               // One restoring step; a loop of steps builds the quotient
               if (c >= b) begin
                  s_d.acc[ins.rd] = (c - b) << 1;
                  s_d.acc[rd1] = {s_q.acc[rd1][ACC_W-2:0], 1'b1};
               end else begin
                  s_d.acc[ins.rd] = c << 1;
                  s_d.acc[rd1] = {s_q.acc[rd1][ACC_W-2:0], 1'b0};
               end
            end
            OP_SQRS: begin
               if (c >= {s_q.acc[rd1][ACC_W-3:0], 2'b01}) begin
                  s_d.acc[ins.rd] = c - {s_q.acc[rd1][ACC_W-3:0], 2'b01};
                  s_d.acc[rd1] = {s_q.acc[rd1][ACC_W-2:0], 1'b1};
               end else begin
                  s_d.acc[rd1] = {s_q.acc[rd1][ACC_W-2:0], 1'b0};
               end
            end
            OP_SLEW: begin
               sdiff = $signed(a) - $signed(c);
               sb = $signed(b);
               if (sdiff >= 0) begin
                  s_d.acc[ins.rd] = (sdiff <= sb) ? a : c + b;
               end else begin
                  s_d.acc[ins.rd] = (-sdiff <= sb) ? a : c - b;
               end
            end
            OP_RND: begin
               s_d.lfsr = s_q.lfsr[0] ? ((s_q.lfsr >> 1) ^ LFSR_TAPS) : (s_q.lfsr >> 1);
               s_d.data[WORD_W*ins.imm[2:0] +: WORD_W] = s_q.lfsr;
            end
            default: begin
               s_d.pc = pc_inc;
            end
         endcase
      end
      // Load data land two cycles after the request, taking the lane register
      if (s_q.ld_wait) begin
         if (s_q.ld_coef) begin
            s_d.coef = mem_rdata;
         end else begin
            s_d.data = mem_rdata;
         end
      end
      // ==========================================================
      // Frame sequencing; a new frame restarts the program even mid-run
      if (frame_start) begin
         s_d.overrun = (s_q.state == ST_RUN);
         s_d.budget_err = 1'b0;
         s_d.state = ST_RUN;
         s_d.pc = '0;
         s_d.cyc = '0;
         s_d.sample_irq = 1'b1;
         if (s_q.blk_cnt + 16'h0001 >= block_len) begin
            s_d.blk_cnt = '0;
            s_d.block_irq = 1'b1;
            s_d.blk_frame = 1'b1;
         end else begin
            s_d.blk_cnt = s_q.blk_cnt + 16'h0001;
            s_d.blk_frame = 1'b0;
         end
      end else if (s_q.state == ST_RUN && !rate_lowered &&
                   s_q.cyc >= 16'(CYCLE_BUDGET)) begin
         s_d.budget_err = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.lfsr <= LFSR_SEED;
      end else begin
         s_q <= s_d;
      end
   end
   // ==========================================================
   // Outputs
   assign mem_addr = s_q.mem_addr;
   assign mem_rd = s_q.mem_rd;
   assign mem_wr = s_q.mem_wr;
   assign mem_wdata = s_q.mem_wdata;
   assign out_sample = s_q.out_sample;
   assign out_chan = s_q.out_chan;
   assign out_valid = s_q.out_valid;
   assign running = (s_q.state == ST_RUN);
   assign sample_irq = s_q.sample_irq;
   assign block_irq = s_q.block_irq;
   assign budget_err = s_q.budget_err;
   assign overrun = s_q.overrun;
   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_one_per_clk;
      exec && ins.op != OP_JMP && ins.op != OP_JBLK && ins.op != OP_HALT && s_q.pc != PC_LAST
         |=> s_q.pc == $past(pc_inc) && running;
   endproperty
   a_one_per_clk: assert property (p_one_per_clk) else $error("pc did not advance by one");
   property p_budget;
      running && !frame_start && !rate_lowered && s_q.cyc >= 16'(CYCLE_BUDGET) |=> budget_err;
   endproperty
   a_budget: assert property (p_budget) else $error("budget overrun not flagged");
   property p_prog_end;
      exec && s_q.pc == PC_LAST && ins.op != OP_JMP && ins.op != OP_JBLK |=> !running;
   endproperty
   a_prog_end: assert property (p_prog_end) else $error("ran past program end");
   property p_mac;
      exec && ins.op == OP_MAC |=> s_q.acc[$past(ins.rd)] == $past(mac_exp);
   endproperty
   a_mac: assert property (p_mac) else $error("accumulate result wrong");
   property p_alu;
      exec && ins.op == OP_ADD |=> s_q.acc[$past(ins.rd)] == $past(alu_sum);
   endproperty
   a_alu: assert property (p_alu) else $error("alu sum wrong");
   property p_frame;
      frame_start |=> sample_irq && running && s_q.pc == 13'h0000 ##1 !sample_irq || $past(frame_start);
   endproperty
   a_frame: assert property (p_frame) else $error("frame event not one pulse");
   property p_circ;
      exec && (ins.op == OP_LDD || ins.op == OP_LDC || ins.op == OP_ST) && ag_in_range
         && ins.imm <= 11'(s_q.ag_len[ins.ag])
         |=> (s_q.ag_ptr[$past(ins.ag)] - s_q.ag_base[$past(ins.ag)]) < s_q.ag_len[$past(ins.ag)];
   endproperty
   a_circ: assert property (p_circ) else $error("pointer left circular buffer");
   property p_clip_pos;
      exec && ins.op == OP_OUT && !clip_ok && !a[ACC_W-1] |=> out_valid && out_sample == CLIP_MAX;
   endproperty
   a_clip_pos: assert property (p_clip_pos) else $error("positive clip wrong");
   property p_clip_neg;
      exec && ins.op == OP_OUT && !clip_ok && a[ACC_W-1] |=> out_valid && out_sample == CLIP_MIN;
   endproperty
   a_clip_neg: assert property (p_clip_neg) else $error("negative clip wrong");
   property p_load;
      mem_rd && !mem_wr ##1 1'b1 |=> (s_q.data == $past(mem_rdata) || s_q.coef == $past(mem_rdata));
   endproperty
   a_load: assert property (p_load) else $error("load line not captured");
endmodule : audio_dsp_core_datapath
`default_nettype wire

/* logic/prog_mem.sv */
// Instruction store with registered read data
`timescale 1ns/1ps
`default_nettype none
module prog_mem (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Core port
   prog_if.mem port
);
   import dsp_core_pkg::*;
   // ==========================================================
   // Storage, left unreset so it maps onto block RAM
   logic [WORD_W-1:0] mem [PROG_WORDS];
   logic [WORD_W-1:0] rdata_q;
   always_ff @(posedge clk) begin
      if (port.we) begin
         mem[port.waddr] <= port.wdata;
      end
      rdata_q <= mem[port.raddr];
   end
   // Reset only masks the output word to a no-op
   logic rst_seen_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
      end
   end
   assign port.rdata = rst_seen_q ? rdata_q : '0;
endmodule : prog_mem
`default_nettype wire

/* logic/unused_placeholder_none.sv */
// Intentionally empty design unit list terminator
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* shared/dsp_core_pkg.sv */
// Shared constants, opcodes and instruction layout for the audio datapath core
package dsp_core_pkg;
   // ==========================================================
   // Widths and sizes
   localparam int PROG_WORDS = 8192;
   localparam int PC_W = 13;
   localparam int WORD_W = 32;
   localparam int LANES = 8;
   localparam int LINE_W = 256;
   localparam int ACC_N = 16;
   localparam int ACC_W = 80;
   localparam int MUL_N = 4;
   localparam int COEF_W = 64;
   localparam int PROD_W = 96;
   localparam int AG_N = 16;
   localparam int MEM_AW = 16;
   localparam int SER_W = 24;
   localparam int HEAD_BITS = 8;
   localparam int FRAC_DATA = 24;
   localparam int FRAC_ACC = 56;
   localparam int CNT_W = 16;
   localparam logic [PC_W-1:0] PC_LAST = 13'h1fff;
   // ==========================================================
   // Cycle budget per sample
   localparam int CORE_CLK_KHZ = 294912;
   localparam int REDUCED_CLK_KHZ = 147456;
   localparam int SAMPLE_KHZ = 48;
   localparam int FULL_BUDGET = CORE_CLK_KHZ / SAMPLE_KHZ;
   localparam int REDUCED_BUDGET = REDUCED_CLK_KHZ / SAMPLE_KHZ;
   localparam longint MAC_PER_SEC = 64'(MUL_N) * 64'(CORE_CLK_KHZ) * 64'd1000;
   // ==========================================================
   // Clipper limits, LFSR seed and taps, and accumulator unity
   localparam logic [SER_W-1:0] CLIP_MAX = 24'h7fffff;
   localparam logic [SER_W-1:0] CLIP_MIN = 24'h800000;
   localparam logic [WORD_W-1:0] LFSR_SEED = 32'h00000001;
   localparam logic [WORD_W-1:0] LFSR_TAPS = 32'h80200003;
   localparam logic [ACC_W-1:0] ACC_ONE = 80'h00000100000000000000;
   // ==========================================================
   // Opcodes and instruction word
   typedef enum logic [4:0] {
      OP_NOP = 5'h00, OP_HALT = 5'h01, OP_LDC = 5'h02, OP_LDD = 5'h03,
      OP_ST = 5'h04, OP_MAC = 5'h05, OP_CLR = 5'h06, OP_ADD = 5'h07,
      OP_SUB = 5'h08, OP_IADD = 5'h09, OP_IN = 5'h0a, OP_OUT = 5'h0b,
      OP_AGB = 5'h0c, OP_AGL = 5'h0d, OP_JMP = 5'h0e, OP_JBLK = 5'h0f,
      OP_SHF = 5'h10, OP_LOG2 = 5'h11, OP_EXP2 = 5'h12, OP_DIVS = 5'h13,
      OP_SQRS = 5'h14, OP_SLEW = 5'h15, OP_RND = 5'h16
   } op_t;
   typedef struct packed {
      op_t op;
      logic [3:0] rd;
      logic [3:0] ra;
      logic [3:0] rb;
      logic [3:0] ag;
      logic [10:0] imm;
   } instr_t;
   typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} state_t;
endpackage : dsp_core_pkg

/* shared/prog_if.sv */
// Program memory port between the core and its instruction store
`timescale 1ns/1ps
`default_nettype none
interface prog_if;
   import dsp_core_pkg::*;
   logic [PC_W-1:0] raddr;
   logic [PC_W-1:0] waddr;
   logic we;
   logic [WORD_W-1:0] wdata;
   logic [WORD_W-1:0] rdata;
   modport core (output raddr, output waddr, output we, output wdata, input rdata);
   modport mem (input raddr, input waddr, input we, input wdata, output rdata);
endinterface : prog_if
`default_nettype wire

/* verification/mem_model.sv */
// Behavioural data memory standing on the far side of the core's load/store port
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   // Clock
   input wire logic clk,
   // Core data port
   input wire logic [dsp_core_pkg::MEM_AW-1:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [dsp_core_pkg::LINE_W-1:0] mem_wdata,
   output logic [dsp_core_pkg::LINE_W-1:0] mem_rdata
);
   import dsp_core_pkg::*;
   // ==========================================================
   // Storage, sixteen lines is plenty for the bench programs
   logic [LINE_W-1:0] lines [0:15];
   logic [MEM_AW-1:0] last_wr;
   initial mem_rdata = '0;
   initial last_wr = '0;
   // ==========================================================
   // Whole 256-bit lines; read data valid only in the cycle after the request
   always @(posedge clk) begin
      if (mem_rd) begin
         mem_rdata <= lines[mem_addr[3:0]];
      end else begin
         mem_rdata <= ~mem_rdata; // Not held, so a late capture shows garbage
      end
      if (mem_wr) begin
         lines[mem_addr[3:0]] <= mem_wdata;
         last_wr <= mem_addr;
      end
   end
endmodule : mem_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the audio datapath core
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dsp_core_pkg::*;
   // ==========================================================
   // Bench signals
   logic clk, rst, frame_start, rate_lowered, prog_we, mem_rd, mem_wr, out_valid;
   logic running, sample_irq, block_irq, budget_err, overrun;
   logic [CNT_W-1:0] block_len;
   logic [PC_W-1:0] prog_waddr;
   logic [WORD_W-1:0] prog_wdata;
   logic [MEM_AW-1:0] mem_addr;
   logic [LINE_W-1:0] mem_wdata, mem_rdata;
   logic [SER_W-1:0] in_sample, out_sample;
   logic [3:0] out_chan;
   int num_errors = 0;
   int samples_checked = 0;
   localparam logic [63:0] COEFS [8] = '{64'h0100000000000000, 64'h0100000000000000,
      64'h0100000000000000, 64'h0100000000000000, 64'h0100000000000000,
      64'h0080000000000000, 64'hfe00000000000000, 64'h7f00000000000000};
   localparam logic [31:0] XS [8] = '{32'h00400000, 32'hffe66666, 32'h02000000,
      32'hfe000000, 32'hff000000, 32'h01000000, 32'h00800000, 32'h7f000000};
   // ==========================================================
   // Design and far side; short budget keeps the run brief
   audio_dsp_core_datapath #(.CYCLE_BUDGET(40)) dut (.clk(clk), .rst(rst),
      .frame_start(frame_start), .rate_lowered(rate_lowered), .block_len(block_len),
      .prog_we(prog_we), .prog_waddr(prog_waddr), .prog_wdata(prog_wdata),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .in_sample(in_sample), .out_sample(out_sample),
      .out_chan(out_chan), .out_valid(out_valid), .running(running),
      .sample_irq(sample_irq), .block_irq(block_irq), .budget_err(budget_err),
      .overrun(overrun));
   mem_model far (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ==========================================================
   // Shared helpers
   task automatic check(input logic [LINE_W-1:0] seen, input logic [LINE_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   function automatic logic [WORD_W-1:0] ins(input op_t op, input logic [3:0] rd,
      input logic [3:0] ra, input logic [10:0] imm);
      instr_t w;
      w = '{op: op, rd: rd, ra: ra, rb: 4'h0, ag: 4'h0, imm: imm};
      return w;
   endfunction : ins
   task automatic wr(input logic [PC_W-1:0] a, input logic [WORD_W-1:0] d);
      @(posedge clk);
      prog_we <= 1'b1;
      prog_waddr <= a;
      prog_wdata <= d;
      @(posedge clk);
      prog_we <= 1'b0;
   endtask : wr
   task automatic start();
      @(posedge clk);
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      #1;
   endtask : start
   task automatic wait_idle();
      int n;
      n = 0;
      while (running !== 1'b0 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      check(running, 1'b0);
   endtask : wait_idle
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 check({running, out_valid, sample_irq, block_irq, budget_err, overrun}, 0);
   endtask : do_reset
   // Ring of three lines from 4: coef at 4, data at 6, store wraps to 5
   task automatic load_prog();
      wr(0, ins(OP_AGB, 0, 0, 11'h004));
      wr(1, ins(OP_AGL, 0, 0, 11'h003));
      wr(2, ins(OP_LDC, 0, 0, 11'h002));
      wr(3, ins(OP_LDD, 0, 0, 11'h002));
      wr(4, ins(OP_CLR, 0, 0, 11'h000));
      wr(5, ins(OP_NOP, 0, 0, 11'h000));
      wr(6, ins(OP_MAC, 0, 0, 11'h000));
      wr(7, ins(OP_ST, 0, 0, 11'h000));
      wr(8, ins(OP_OUT, 0, 0, 11'h005));
      wr(9, ins(OP_HALT, 0, 0, 11'h000));
   endtask : load_prog
   // ==========================================================
   // Scenarios
   task automatic t_clip();
      logic signed [127:0] p;
      logic [79:0] acc;
      logic [SER_W-1:0] exp;
      int k;
      for (int i = 0; i < 8; i++) begin
         far.lines[4] = {192'h0, COEFS[i]};
         far.lines[5] = '0;
         far.lines[6] = {128'h0, 64'h123456789abcdef0, 32'h0, XS[i]};
         p = 128'($signed(COEFS[i])) * 128'($signed(XS[i]));
         acc = 80'(p >>> 24);
         exp = (acc[79:56] == {24{acc[79]}}) ? acc[56:33] : (acc[79] ? CLIP_MIN : CLIP_MAX);
         start();
         check({running, sample_irq, block_irq}, 3'h7);
         k = 0;
         while (out_valid !== 1'b1 && k < 50) begin
            @(posedge clk);
            #1 k++;
         end
         check(k, 9);
         check(out_sample, exp);
         check(out_chan, 4'h5);
         wait_idle();
         check(far.lines[5], {128'h0, 64'h123456789abcdef0, 32'h0, XS[i]});
         check(far.last_wr, 16'h0005);
      end
   endtask : t_clip
   task automatic t_budget();
      wr(9, ins(OP_JMP, 0, 0, 11'h009));
      start();
      repeat (20) @(posedge clk);
      #1 check(budget_err, 1'b0);
      repeat (40) @(posedge clk);
      #1 check(budget_err, 1'b1);
      wr(9, ins(OP_HALT, 0, 0, 11'h000));
      @(posedge clk);
      rate_lowered <= 1'b1;
      start();
      check({overrun, budget_err}, 2'h2);
      repeat (60) @(posedge clk);
      #1 check({running, budget_err}, 2'h2);
      do_reset();
      @(posedge clk);
      rate_lowered <= 1'b0;
   endtask : t_budget
   task automatic t_block();
      @(posedge clk);
      block_len <= 16'h0003;
      for (int i = 1; i <= 6; i++) begin
         start();
         check({sample_irq, block_irq}, {1'b1, i % 3 == 0});
         @(posedge clk);
         #1 check({sample_irq, block_irq}, 2'h0);
         wait_idle();
      end
   endtask : t_block
   // Serial word in, doubled by the ALU, out unclipped; ends on the last program word
   task automatic t_alu();
      int k;
      wr(0, ins(OP_AGB, 0, 0, 11'h004));
      wr(1, ins(OP_LDC, 0, 0, 11'h000));
      wr(2, ins(OP_IN, 0, 0, 11'h000));
      wr(3, ins(OP_CLR, 0, 0, 11'h000));
      wr(4, ins(OP_MAC, 0, 0, 11'h000));
      wr(5, ins(OP_ADD, 2, 0, 11'h000));
      wr(6, ins(OP_OUT, 0, 2, 11'h003));
      wr(7, ins(OP_JMP, 3, 0, 11'h7ff));
      wr(PC_LAST, ins(OP_NOP, 0, 0, 11'h000));
      far.lines[4] = {192'h0, 64'h0100000000000000};
      in_sample <= 24'h200000;
      start();
      k = 0;
      while (out_valid !== 1'b1 && k < 50) begin
         @(posedge clk);
         #1 k++;
      end
      check(k, 7);
      check(out_sample, 24'h400000);
      check(out_chan, 4'h3);
      repeat (2) @(posedge clk);
      #1 check(running, 1'b0);
   endtask : t_alu
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      rst = 1'b1;
      frame_start = 1'b0;
      rate_lowered = 1'b0;
      prog_we = 1'b0;
      prog_waddr = '0;
      prog_wdata = '0;
      block_len = 16'h0001;
      in_sample = '0;
      do_reset();
      load_prog();
      t_clip();
      t_budget();
      load_prog();
      t_block();
      t_alu();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      stop_test();
   end
endmodule : tb
`default_nettype wire
